// File: asram_ctrl.sv
`timescale 1ns/10ps
module asram_ctrl #(
  parameter int recovery_cycles = asram_pkg::recovery_cycles_default
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [asram_pkg::addr_width-1:0] req_addr,
  input wire logic [asram_pkg::data_width-1:0] req_wdata,
  input wire logic retain_req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [asram_pkg::data_width-1:0] rsp_rdata,
  output logic retain_active,
  output logic [asram_pkg::addr_width-1:0] word_address,
  output logic select_n,
  output logic store_n,
  output logic drive_en_n,
  input wire logic [asram_pkg::data_width-1:0] byte_lines_in,
  output logic [asram_pkg::data_width-1:0] byte_lines_out,
  output logic byte_lines_oe_n
);
  asram_pkg::asram_state_t state;
  asram_pkg::asram_state_t next_state;
  asram_timer_if tmr ();

  asram_timer u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .tmr(tmr)
  );

  function automatic logic [asram_pkg::count_width-1:0] cyc(input int n);
    cyc = asram_pkg::count_width'(n - 1);
  endfunction : cyc

  // One timer serves every timed state, so its done flag only counts in the state that loaded it.
  function automatic logic expired(input asram_pkg::asram_state_t current,
    input asram_pkg::asram_state_t want, input logic done);
    expired = (current == want) && done;
  endfunction : expired

  // The memory stays selected from the turn-off gap until the cycle after write end.
  function automatic logic selects_for_write(input asram_pkg::asram_state_t s);
    selects_for_write = (s == asram_pkg::asram_wr_gap)
      || (s == asram_pkg::asram_wr_strobe)
      || (s == asram_pkg::asram_wr_end);
  endfunction : selects_for_write

  // The controller drives the byte lines from the store strobe through one cycle of hold.
  function automatic logic drives_data(input asram_pkg::asram_state_t s);
    drives_data = (s == asram_pkg::asram_wr_strobe) || (s == asram_pkg::asram_wr_end);
  endfunction : drives_data

  wire logic idle = (state == asram_pkg::asram_idle);
  wire logic start_read = idle && req_valid && !req_write && !retain_req;
  wire logic start_write = idle && req_valid && req_write && !retain_req;
  wire logic enter_retain = idle && retain_req;
  wire logic rd_done = expired(state, asram_pkg::asram_rd_wait, tmr.done);
  wire logic gap_done = expired(state, asram_pkg::asram_wr_gap, tmr.done);
  wire logic strobe_done = expired(state, asram_pkg::asram_wr_strobe, tmr.done);
  wire logic leave_retain = (state == asram_pkg::asram_retain) && !retain_req;
  wire logic recover_done = expired(state, asram_pkg::asram_recover, tmr.done);

  // Each timed phase loads the timer on the edge that enters it; a load of n - 1 holds the phase for n cycles.
  always_comb begin
    next_state = state;
    tmr.load = 1'b0;
    tmr.value = '0;
    unique case (state)
      asram_pkg::asram_idle: begin
        if (enter_retain) begin
          next_state = asram_pkg::asram_retain;
        end else if (start_read) begin
          next_state = asram_pkg::asram_rd_wait;
          tmr.load = 1'b1;
          tmr.value = cyc(asram_pkg::access_cycles);
        end else if (start_write) begin
          // A short gap lets a memory still driving from a read let go before the controller drives.
          next_state = asram_pkg::asram_wr_gap;
          tmr.load = 1'b1;
          tmr.value = cyc(asram_pkg::turn_off_cycles);
        end
      end
      asram_pkg::asram_rd_wait: begin
        if (rd_done) begin
          next_state = asram_pkg::asram_idle;
        end
      end
      asram_pkg::asram_wr_gap: begin
        if (gap_done) begin
          next_state = asram_pkg::asram_wr_strobe;
          tmr.load = 1'b1;
          tmr.value = cyc(asram_pkg::overlap_cycles);
        end
      end
      asram_pkg::asram_wr_strobe: begin
        if (strobe_done) begin
          next_state = asram_pkg::asram_wr_end;
        end
      end
      asram_pkg::asram_wr_end: begin
        next_state = asram_pkg::asram_idle;
      end
      asram_pkg::asram_retain: begin
        // Select stays high through retention and recovery, so the memory ignores its other pins.
        if (leave_retain) begin
          next_state = asram_pkg::asram_recover;
          tmr.load = 1'b1;
          tmr.value = cyc(recovery_cycles);
        end
      end
      asram_pkg::asram_recover: begin
        if (recover_done) begin
          next_state = asram_pkg::asram_idle;
        end
      end
      default: begin
        next_state = asram_pkg::asram_idle;
      end
    endcase
  end

  // Strobes are decoded from the next state so that every pin leaves a flip-flop.
  wire logic next_select_n = !((next_state == asram_pkg::asram_rd_wait)
    || selects_for_write(next_state));
  wire logic next_store_n = (next_state != asram_pkg::asram_wr_strobe);
  wire logic next_drive_en_n = (next_state != asram_pkg::asram_rd_wait);
  wire logic next_oe_n = !drives_data(next_state);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= asram_pkg::asram_idle;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      select_n <= 1'b1;
      store_n <= 1'b1;
    end else begin
      select_n <= next_select_n;
      store_n <= next_store_n;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      drive_en_n <= 1'b1;
      byte_lines_oe_n <= 1'b1;
    end else begin
      drive_en_n <= next_drive_en_n;
      byte_lines_oe_n <= next_oe_n;
    end
  end

  // The address is latched when a request is taken and stands through the whole cycle.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      word_address <= '0;
    end else if (start_read || start_write) begin
      word_address <= req_addr;
    end
  end

  // Write data is latched only for writes; a read leaves the last byte in place.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      byte_lines_out <= '0;
    end else if (start_write) begin
      byte_lines_out <= req_wdata;
    end
  end

  // Read data is taken on the edge that ends the access phase, after every access delay has passed.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= rd_done;
      if (rd_done) begin
        rsp_rdata <= byte_lines_in;
      end
    end
  end

  // Ready predicts the next cycle, so a caller that samples it between edges never meets a busy controller.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
      retain_active <= 1'b0;
    end else begin
      req_ready <= (next_state == asram_pkg::asram_idle) && !retain_req;
      retain_active <= (next_state == asram_pkg::asram_retain);
    end
  end
endmodule : asram_ctrl

// File: asram_pkg.sv
package asram_pkg;
  localparam int clock_period_ns = 50;
  localparam int addr_width = 19;
  localparam int data_width = 8;
  localparam int mem_bytes = 524288;
  localparam int access_time_ns = 45;
  localparam int cycle_time_ns = 45;
  localparam int write_overlap_ns = 35;
  localparam int data_setup_ns = 25;
  localparam int turn_off_ns = 18;
  localparam int recovery_time_us = 5000;
  localparam int access_cycles_raw = (access_time_ns + clock_period_ns - 1) / clock_period_ns;
  localparam int access_cycles = (access_cycles_raw < 1) ? 1 : access_cycles_raw;
  localparam int overlap_cycles_raw = (write_overlap_ns + clock_period_ns - 1) / clock_period_ns;
  localparam int overlap_cycles = (overlap_cycles_raw < 1) ? 1 : overlap_cycles_raw;
  localparam int turn_off_cycles_raw = (turn_off_ns + clock_period_ns - 1) / clock_period_ns;
  localparam int turn_off_cycles = (turn_off_cycles_raw < 1) ? 1 : turn_off_cycles_raw;
  localparam int recovery_cycles_default = (recovery_time_us * 1000) / clock_period_ns;
  localparam int count_width = 20;

  typedef enum logic [2:0] {
    asram_idle = 3'b000,
    asram_rd_wait = 3'b001,
    asram_wr_gap = 3'b010,
    asram_wr_strobe = 3'b011,
    asram_wr_end = 3'b100,
    asram_retain = 3'b101,
    asram_recover = 3'b110
  } asram_state_t;
endpackage : asram_pkg

// File: asram_timer_if.sv
`timescale 1ns/10ps
interface asram_timer_if;
  logic load;
  logic [asram_pkg::count_width-1:0] value;
  logic done;
  modport owner (output load, output value, input done);
  modport timer (input load, input value, output done);
endinterface : asram_timer_if

// File: asram_timer.sv
`timescale 1ns/10ps
module asram_timer (
  input wire logic clock,
  input wire logic rst_n,
  asram_timer_if.timer tmr
);
  logic [asram_pkg::count_width-1:0] count;

  assign tmr.done = (count == '0);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (tmr.load) begin
      count <= tmr.value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end
endmodule : asram_timer

// File: asram_ctrl_props.sv
`timescale 1ns/10ps
module asram_ctrl_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic retain_req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic retain_active,
  input wire logic [asram_pkg::addr_width-1:0] word_address,
  input wire logic select_n,
  input wire logic store_n,
  input wire logic drive_en_n,
  input wire logic [asram_pkg::data_width-1:0] byte_lines_out,
  input wire logic byte_lines_oe_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire take = req_valid && req_ready && !retain_req;
  a_read_drive: assert property (take && !req_write |=> !select_n && !drive_en_n && store_n)
    else $error("read strobes wrong");
  a_read_resp: assert property (take && !req_write |-> ##2 rsp_valid)
    else $error("read response late");
  a_write_gap: assert property (take && req_write |=> !select_n && store_n && byte_lines_oe_n)
    else $error("write gap wrong");
  a_write_pulse: assert property (take && req_write |-> ##2 !store_n && !select_n ##1 store_n && !select_n)
    else $error("write pulse wrong");
  a_data_hold: assert property ($rose(store_n) |-> $stable(byte_lines_out) && !byte_lines_oe_n)
    else $error("write data not held");
  a_addr_stable: assert property (!store_n |-> $stable(word_address) && !select_n && !byte_lines_oe_n)
    else $error("address moved in write");
  a_select_setup: assert property ($rose(store_n) |-> !select_n && !$past(select_n, 2))
    else $error("select too short before write end");
  a_no_clash: assert property (!byte_lines_oe_n |-> drive_en_n)
    else $error("both sides drive");
  a_retain_idle: assert property (retain_active |-> select_n && store_n)
    else $error("select during retention");
endmodule : asram_ctrl_props

bind asram_ctrl asram_ctrl_props u_props (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
  .req_write(req_write), .retain_req(retain_req), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .retain_active(retain_active), .word_address(word_address), .select_n(select_n), .store_n(store_n),
  .drive_en_n(drive_en_n), .byte_lines_out(byte_lines_out), .byte_lines_oe_n(byte_lines_oe_n));

// File: asram_mem_model.sv
`timescale 1ns/10ps
module asram_mem_model (
  input wire logic [18:0] word_address,
  input wire logic select_n,
  input wire logic store_n,
  input wire logic drive_en_n,
  input wire logic [7:0] byte_lines_out,
  input wire logic byte_lines_oe_n,
  output logic [7:0] byte_lines_in
);
  logic [7:0] mem [0:524287];
  logic [7:0] last = 8'h00;
  logic [18:0] rd_addr;
  logic rd_on = 1'b0;
  wire rd = !select_n && store_n && !drive_en_n;
  wire wr = !select_n && !store_n;
  // Turn-on lags by 10 ns, turn-off by 5 ns, so a release always precedes the next drive.
  always @(rd) rd_on <= #(rd ? 10 : 5) rd;
  always @(word_address) rd_addr <= #10 word_address;
  always @(negedge wr) if (!byte_lines_oe_n) mem[word_address] <= byte_lines_in;
  // A released bus shows the inverse of its last driven value.
  assign byte_lines_in = !byte_lines_oe_n ? byte_lines_out : rd_on ? mem[rd_addr] : ~last;
  always @(byte_lines_in) if (!byte_lines_oe_n || rd_on) last = byte_lines_in;
endmodule : asram_mem_model

// File: async_sram_byte_port_test.sv
`timescale 1ns/10ps
module async_sram_byte_port_test;
  logic clock = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0, retain_req = 1'b0;
  logic [18:0] req_addr = 19'h0;
  logic [7:0] req_wdata = 8'h0;
  logic req_ready, rsp_valid, retain_active, select_n, store_n, drive_en_n, byte_lines_oe_n;
  logic [7:0] rsp_rdata, byte_lines_in, byte_lines_out;
  logic [18:0] word_address;
  int num_errors = 0, cmp_count = 0;
  always #25 clock = ~clock;
  asram_ctrl #(.recovery_cycles(8)) u_dut (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .retain_req(retain_req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .retain_active(retain_active),
    .word_address(word_address), .select_n(select_n), .store_n(store_n), .drive_en_n(drive_en_n),
    .byte_lines_in(byte_lines_in), .byte_lines_out(byte_lines_out), .byte_lines_oe_n(byte_lines_oe_n));
  asram_mem_model u_mem (.word_address(word_address), .select_n(select_n), .store_n(store_n),
    .drive_en_n(drive_en_n), .byte_lines_out(byte_lines_out), .byte_lines_oe_n(byte_lines_oe_n),
    .byte_lines_in(byte_lines_in));
  task automatic print_verdict;
    if (num_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic access(input logic wr, input logic [18:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(negedge clock);
    req_valid = 1'b0;
    n = 0;
    while (!wr && rsp_valid !== 1'b1 && n < 10) begin
      @(negedge clock);
      n++;
    end
    q = (rsp_valid === 1'b1) ? rsp_rdata : 8'hxx;
  endtask : access
  task automatic t_edges;
    logic [18:0] a [3] = '{19'h0, 19'h7ffff, 19'h2aaaa};
    logic [7:0] d [3] = '{8'h5a, 8'ha5, 8'hff};
    logic [7:0] q;
    for (int i = 0; i < 3; i++) access(1'b1, a[i], d[i], q);
    for (int i = 0; i < 3; i++) begin
      access(1'b0, a[i], 8'h0, q);
      chk({11'h0, q}, {11'h0, d[i]});
    end
  endtask : t_edges
  task automatic t_overwrite;
    logic [7:0] q;
    access(1'b1, 19'h55555, 8'h01, q);
    access(1'b1, 19'h55555, 8'hfe, q);
    access(1'b0, 19'h55555, 8'h0, q);
    chk({11'h0, q}, 19'h000fe);
  endtask : t_overwrite
  task automatic t_retain;
    logic [7:0] q;
    int n;
    retain_req = 1'b1;
    repeat (2) @(negedge clock);
    chk({17'h0, retain_active, select_n}, 19'h3);
    retain_req = 1'b0;
    n = 0;
    while (req_ready !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    chk({18'h0, n >= 8 && n < 20}, 19'h1);
    access(1'b0, 19'h0, 8'h0, q);
    chk({11'h0, q}, 19'h0005a);
  endtask : t_retain
  task automatic t_reset;
    logic [7:0] q;
    rst_n = 1'b0;
    @(negedge clock);
    chk({13'h0, req_ready, rsp_valid, select_n, store_n, drive_en_n, byte_lines_oe_n}, 19'h0000f);
    rst_n = 1'b1;
    access(1'b0, 19'h55555, 8'h0, q);
    chk({11'h0, q}, 19'h000fe);
  endtask : t_reset
  initial begin
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    t_edges();
    t_overwrite();
    t_retain();
    t_reset();
    print_verdict();
  end
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
endmodule : async_sram_byte_port_test
